// >>> verilog/strap_cfg_pkg.sv
// constants for the reset strap latch and clock default block
package strap_cfg_pkg;
    localparam int          STRAP_WIDTH       = 8;
    // index/data port pair for the extension register set
    localparam logic [15:0] EXT_INDEX_PORT    = 16'h03D6;
    localparam logic [15:0] EXT_DATA_PORT     = 16'h03D7;
    // extension register indexes
    localparam logic [7:0]  IDX_STRAP_LATCH   = 8'h01;
    localparam logic [7:0]  IDX_CLK_SELECT    = 8'h30;
    localparam logic [7:0]  IDX_CLK_FREQ_LO   = 8'h31;
    localparam logic [7:0]  IDX_CLK_FREQ_MID  = 8'h32;
    localparam logic [7:0]  IDX_CLK_FREQ_HI   = 8'h33;
    localparam logic [7:0]  IDX_CLK_CHOICE    = 8'h34;
    // strap field positions
    localparam int          STRAP_BUS_LSB     = 0;
    localparam int          STRAP_BOARD_BIT   = 2;
    localparam int          STRAP_DISABLE_BIT = 3;
    localparam int          STRAP_EXTCLK_BIT  = 4;
    localparam int          STRAP_OSC_BIT     = 5;
    // synthesizer frequencies in kHz
    localparam int          FREQ_WIDTH        = 17;
    localparam logic [16:0] MCLK_DEFAULT_KHZ  = 17'h0EA60;
    localparam logic [16:0] VCLK0_DEFAULT_KHZ = 17'h06257;
    localparam logic [16:0] VCLK1_DEFAULT_KHZ = 17'h06EA2;
    localparam logic [16:0] FREQ_MIN_KHZ      = 17'h02710;
    localparam logic [16:0] FREQ_MAX_KHZ      = 17'h13880;
    // reset values
    localparam logic [7:0]  STRAP_RESET       = 8'h00;
    localparam logic [1:0]  CLK_CHOICE_RESET  = 2'h0;
    localparam logic [7:0]  INDEX_RESET       = 8'h00;
    typedef enum logic [1:0] {SYNTH_MCLK, SYNTH_VCLK0, SYNTH_VCLK1} synth_sel_t;
endpackage : strap_cfg_pkg

// >>> verilog/strap_sync.sv
// three-stage synchroniser for slow pin levels
`timescale 1ns/1ps
module strap_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             i_mclk,
    input  wire logic [WIDTH-1:0] i_pin,
    output logic      [WIDTH-1:0] o_stable
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync2;
    logic [WIDTH-1:0] sync3;
    logic [WIDTH-1:0] next_stable;

    if (WIDTH < 1) begin : g_width_check
        $error("strap_sync: WIDTH must be positive");
    end

    // a change counts only once stages two and three agree
    always_comb begin
        next_stable = o_stable;
        for (int i = 0; i < WIDTH; i++) begin
            if (sync2[i] == sync3[i]) next_stable[i] = sync3[i];
        end
    end

    // no reset here: the pins must keep flowing through while reset is held
    always_ff @(posedge i_mclk) begin
        meta     <= i_pin;
        sync2    <= meta;
        sync3    <= sync2;
        o_stable <= next_stable;
    end
endmodule : strap_sync

// >>> verilog/strap_config_block.sv
// reset strap capture, decode and clock synthesizer power-on defaults
//
// What this block does
// - sample the eight memory data straps when the bus reset is released
// - the two lowest strap bits select the host bus interface type
// - strap bit 2 records motherboard or add-in card mounting
// - strap bit 3 captured at reset can disable the whole chip
// - strap bit 4 picks internal synthesizer or external clock sources
// - with internal synthesizer, strap bit 5 picks crystal or TTL oscillator reference
// - all eight captured strap bits are readable in an extension register
// - memory clock synthesizer defaults to 60 MHz at reset
// - fixed video clocks default nearest 25.175 MHz and 28.322 MHz
// - reset clears the video clock choice bits, selecting the first fixed clock
// - external clocks: pixel clock from crystal pin, memory clock from its pin
// - synthesizers programmable from 10 MHz to 80 MHz within 0.5 percent
`timescale 1ns/1ps
module strap_config_block
    import strap_cfg_pkg::*;
(
    input  wire logic                   i_mclk,
    input  wire logic                   i_reset,
    input  wire logic [STRAP_WIDTH-1:0] i_memory_data_straps,
    input  wire logic [15:0]            i_io_addr,
    input  wire logic                   i_io_wr,
    input  wire logic                   i_io_rd,
    input  wire logic [7:0]             i_io_wdata,
    output logic      [7:0]             o_io_rdata,
    output logic      [7:0]             o_strap_config_latch,
    output logic      [1:0]             o_bus_type,
    output logic                        o_on_motherboard,
    output logic                        o_chip_disable,
    output logic                        o_external_clocks,
    output logic                        o_ref_is_oscillator,
    output logic                        o_pixel_clk_from_crystal_pin,
    output logic                        o_mem_clk_from_mclk_pin,
    output logic      [FREQ_WIDTH-1:0]  o_mclk_khz,
    output logic      [FREQ_WIDTH-1:0]  o_vclk0_khz,
    output logic      [FREQ_WIDTH-1:0]  o_vclk1_khz,
    output logic      [1:0]             o_video_clock_choice_bits
);
    logic [STRAP_WIDTH-1:0] sync_straps;
    logic                   release_pending;
    logic [7:0]             index;
    synth_sel_t             synth_sel;
    logic [15:0]            freq_stage;

    logic [STRAP_WIDTH-1:0] next_straps;
    logic                   next_release_pending;
    logic [7:0]             next_index;
    synth_sel_t             next_synth_sel;
    logic [15:0]            next_freq_stage;
    logic [FREQ_WIDTH-1:0]  next_mclk_khz;
    logic [FREQ_WIDTH-1:0]  next_vclk0_khz;
    logic [FREQ_WIDTH-1:0]  next_vclk1_khz;
    logic [1:0]             next_clock_choice;
    logic [7:0]             next_rdata;
    logic [FREQ_WIDTH-1:0]  written_khz;
    logic                   data_wr;

    strap_sync #(
        .WIDTH    (STRAP_WIDTH)
    ) u_strap_sync (
        .i_mclk   (i_mclk),
        .i_pin    (i_memory_data_straps),
        .o_stable (sync_straps)
    );

    assign data_wr     = i_io_wr && (i_io_addr == EXT_DATA_PORT);
    assign written_khz = {i_io_wdata[0], freq_stage};

    always_comb begin
        next_straps          = o_strap_config_latch;
        next_release_pending = release_pending;
        next_index           = index;
        next_synth_sel       = synth_sel;
        next_freq_stage      = freq_stage;
        next_mclk_khz        = o_mclk_khz;
        next_vclk0_khz       = o_vclk0_khz;
        next_vclk1_khz       = o_vclk1_khz;
        next_clock_choice    = o_video_clock_choice_bits;
        next_rdata           = o_io_rdata;

        // capture on the first clock after the reset falls; the strap
        // byte is otherwise frozen, so no write path reaches it
        if (release_pending) begin
            next_straps          = sync_straps;
            next_release_pending = 1'b0;
        end

        if (i_io_wr && i_io_addr == EXT_INDEX_PORT) next_index = i_io_wdata;

        if (data_wr) begin
            unique case (index)
                IDX_CLK_SELECT: begin
                    if (i_io_wdata[1:0] != 2'h3) next_synth_sel = synth_sel_t'(i_io_wdata[1:0]);
                end
                IDX_CLK_FREQ_LO:  next_freq_stage[7:0]  = i_io_wdata;
                IDX_CLK_FREQ_MID: next_freq_stage[15:8] = i_io_wdata;
                // the high write commits; out of range values are refused
                IDX_CLK_FREQ_HI: begin
                    if (written_khz >= FREQ_MIN_KHZ && written_khz <= FREQ_MAX_KHZ) begin
                        unique case (synth_sel)
                            SYNTH_MCLK:  next_mclk_khz  = written_khz;
                            SYNTH_VCLK0: next_vclk0_khz = written_khz;
                            SYNTH_VCLK1: next_vclk1_khz = written_khz;
                            default:     next_mclk_khz  = o_mclk_khz;
                        endcase
                    end
                end
                IDX_CLK_CHOICE: next_clock_choice = i_io_wdata[1:0];
                default:        next_index        = index;
            endcase
        end

        if (i_io_rd) begin
            next_rdata = 8'h00;
            if (i_io_addr == EXT_INDEX_PORT) next_rdata = index;
            if (i_io_addr == EXT_DATA_PORT) begin
                unique case (index)
                    IDX_STRAP_LATCH:  next_rdata = o_strap_config_latch;
                    IDX_CLK_SELECT:   next_rdata = {6'h00, synth_sel};
                    IDX_CLK_FREQ_LO:  next_rdata = freq_stage[7:0];
                    IDX_CLK_FREQ_MID: next_rdata = freq_stage[15:8];
                    IDX_CLK_CHOICE:   next_rdata = {6'h00, o_video_clock_choice_bits};
                    default:          next_rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_strap_config_latch      <= STRAP_RESET;
            release_pending           <= 1'b1;
            index                     <= INDEX_RESET;
            synth_sel                 <= SYNTH_MCLK;
            freq_stage                <= 16'h0000;
            o_mclk_khz                <= MCLK_DEFAULT_KHZ;
            o_vclk0_khz               <= VCLK0_DEFAULT_KHZ;
            o_vclk1_khz               <= VCLK1_DEFAULT_KHZ;
            o_video_clock_choice_bits <= CLK_CHOICE_RESET;
            o_io_rdata                <= 8'h00;
        end else begin
            o_strap_config_latch      <= next_straps;
            release_pending           <= next_release_pending;
            index                     <= next_index;
            synth_sel                 <= next_synth_sel;
            freq_stage                <= next_freq_stage;
            o_mclk_khz                <= next_mclk_khz;
            o_vclk0_khz               <= next_vclk0_khz;
            o_vclk1_khz               <= next_vclk1_khz;
            o_video_clock_choice_bits <= next_clock_choice;
            o_io_rdata                <= next_rdata;
        end
    end

    // decoded outputs follow the byte being latched, so they settle with it
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_bus_type                   <= 2'h0;
            o_on_motherboard             <= 1'b0;
            o_chip_disable               <= 1'b0;
            o_external_clocks            <= 1'b0;
            o_ref_is_oscillator          <= 1'b0;
            o_pixel_clk_from_crystal_pin <= 1'b0;
            o_mem_clk_from_mclk_pin      <= 1'b0;
        end else begin
            o_bus_type                   <= next_straps[STRAP_BUS_LSB +: 2];
            o_on_motherboard             <= next_straps[STRAP_BOARD_BIT];
            o_chip_disable               <= next_straps[STRAP_DISABLE_BIT];
            o_external_clocks            <= next_straps[STRAP_EXTCLK_BIT];
            o_ref_is_oscillator          <= !next_straps[STRAP_EXTCLK_BIT]
                                            && next_straps[STRAP_OSC_BIT];
            o_pixel_clk_from_crystal_pin <= next_straps[STRAP_EXTCLK_BIT];
            o_mem_clk_from_mclk_pin      <= next_straps[STRAP_EXTCLK_BIT];
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    a_strap_capture: assert property ($fell(i_reset) |=> o_strap_config_latch == $past(sync_straps))
        else $error("strap byte not captured at reset release");
    a_bus_type_dec: assert property ($fell(i_reset) |=> o_bus_type == $past(sync_straps[1:0]))
        else $error("bus type does not follow straps");
    a_board_place: assert property ($fell(i_reset)
        |=> o_on_motherboard == $past(sync_straps[STRAP_BOARD_BIT]))
        else $error("board placement mismatch");
    a_chip_disable: assert property ($fell(i_reset)
        |=> o_chip_disable == $past(sync_straps[STRAP_DISABLE_BIT]))
        else $error("chip disable mismatch");
    a_clock_source: assert property (o_external_clocks |-> !o_ref_is_oscillator
        && o_pixel_clk_from_crystal_pin && o_mem_clk_from_mclk_pin)
        else $error("external clock routing wrong");
    a_ref_kind: assert property ($fell(i_reset) ##1 !o_strap_config_latch[STRAP_EXTCLK_BIT]
        |-> o_ref_is_oscillator == o_strap_config_latch[STRAP_OSC_BIT])
        else $error("reference kind wrong");
    a_latch_hold: assert property (!release_pending |=> $stable(o_strap_config_latch))
        else $error("strap byte changed after capture");
    a_clock_defaults: assert property ($fell(i_reset) |-> o_mclk_khz == MCLK_DEFAULT_KHZ
        && o_vclk0_khz == VCLK0_DEFAULT_KHZ && o_vclk1_khz == VCLK1_DEFAULT_KHZ)
        else $error("clock defaults wrong after reset");
    a_choice_clear: assert property ($fell(i_reset) |-> o_video_clock_choice_bits == 2'h0)
        else $error("video clock choice not cleared");
    a_freq_range: assert property (o_mclk_khz >= FREQ_MIN_KHZ && o_mclk_khz <= FREQ_MAX_KHZ
        && o_vclk0_khz >= FREQ_MIN_KHZ && o_vclk0_khz <= FREQ_MAX_KHZ
        && o_vclk1_khz >= FREQ_MIN_KHZ && o_vclk1_khz <= FREQ_MAX_KHZ)
        else $error("synthesizer frequency out of range");
    a_freq_refuse: assert property (data_wr && index == IDX_CLK_FREQ_HI
        && (written_khz < FREQ_MIN_KHZ || written_khz > FREQ_MAX_KHZ) |=> $stable(o_mclk_khz)
        && $stable(o_vclk0_khz) && $stable(o_vclk1_khz))
        else $error("out of range frequency was committed");
    // capture edge excluded: the strap load itself changes the latch there, write or no write
    a_strap_refuse: assert property (!release_pending && data_wr && index == IDX_STRAP_LATCH
        |=> $stable(o_strap_config_latch))
        else $error("strap byte changed by a write");
    a_rdata_hold: assert property (!i_io_rd |=> $stable(o_io_rdata))
        else $error("read data changed without a read");
    a_latch_read: assert property (i_io_rd && i_io_addr == EXT_DATA_PORT
        && index == IDX_STRAP_LATCH |=> o_io_rdata == $past(o_strap_config_latch))
        else $error("strap byte read back wrong");
endmodule : strap_config_block

// >>> verification/strap_board_model.sv
// board strap resistors and reference source seen from the memory data pins
`timescale 1ns/1ps
module strap_board_model (
    input  wire logic       i_mclk,
    input  wire logic       i_reset,
    input  wire logic [7:0] i_pattern,
    output logic      [7:0] o_straps
);
    // reference frequency the synthesizers count from, in MHz
    localparam real REF_MHZ = 14.31818;

    logic [7:0] next_straps;

    always_comb begin
        if (i_reset) begin
            // every strap line is held at a defined level; reserved bits pulled low
            next_straps = {2'h0, i_pattern[5:0]};
        end else begin
            // after release the memory bus carries traffic, so the pins keep moving
            next_straps = ~o_straps;
        end
    end

    always_ff @(posedge i_mclk) begin
        o_straps <= next_straps;
    end
endmodule : strap_board_model

// >>> verification/strap_config_block_test.sv
// self-checking bench for the strap capture and clock default block
`timescale 1ns/1ps
module strap_config_block_test;
    import strap_cfg_pkg::*;
    logic        mclk;
    logic        rst;
    logic [7:0]  pattern;
    logic [7:0]  straps;
    logic [15:0] io_addr;
    logic        io_wr;
    logic        io_rd;
    logic [7:0]  io_wdata;
    logic [7:0]  rdata;
    logic [7:0]  latch;
    logic [1:0]  bus_type;
    logic        on_mb;
    logic        chip_dis;
    logic        ext_clk;
    logic        ref_osc;
    logic        pix_xtal;
    logic        mem_pin;
    logic [16:0] mclk_khz;
    logic [16:0] vclk0_khz;
    logic [16:0] vclk1_khz;
    logic [1:0]  choice;
    logic [7:0]  rd_val;
    logic [16:0] exp_f [3];
    int          err_count;
    int          comparisons;
    int          cycles;
    logic [7:0]  pats [5] = '{8'h00, 8'h3F, 8'h15, 8'h2A, 8'h0B};
    int          fsel [6] = '{0, 2, 1, 1, 1, 0};
    logic [16:0] fval [6] = '{17'h02710, 17'h13880, 17'h13881, 17'h0270F, 17'h0C350, 17'h1FFFF};

    strap_board_model u_strap_board_model (.i_mclk(mclk), .i_reset(rst), .i_pattern(pattern),
        .o_straps(straps));

    strap_config_block u_strap_config_block (.i_mclk(mclk), .i_reset(rst),
        .i_memory_data_straps(straps), .i_io_addr(io_addr), .i_io_wr(io_wr), .i_io_rd(io_rd),
        .i_io_wdata(io_wdata), .o_io_rdata(rdata), .o_strap_config_latch(latch),
        .o_bus_type(bus_type), .o_on_motherboard(on_mb), .o_chip_disable(chip_dis),
        .o_external_clocks(ext_clk), .o_ref_is_oscillator(ref_osc),
        .o_pixel_clk_from_crystal_pin(pix_xtal), .o_mem_clk_from_mclk_pin(mem_pin),
        .o_mclk_khz(mclk_khz), .o_vclk0_khz(vclk0_khz), .o_vclk1_khz(vclk1_khz),
        .o_video_clock_choice_bits(choice));

    task automatic check(input logic [16:0] seen, input logic [16:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    // one strobe per call; the strobe drops a full cycle before the next can rise
    task automatic io_cycle(input logic [15:0] addr, input logic wr, input logic [7:0] data);
        @(negedge mclk);
        io_addr = addr;
        io_wr = wr;
        io_rd = !wr;
        io_wdata = data;
        @(negedge mclk);
        io_wr = 1'b0;
        io_rd = 1'b0;
    endtask : io_cycle

    task automatic ext_write(input logic [7:0] idx, input logic [7:0] data);
        io_cycle(EXT_INDEX_PORT, 1'b1, idx);
        io_cycle(EXT_DATA_PORT, 1'b1, data);
    endtask : ext_write

    task automatic ext_read(input logic [7:0] idx, output logic [7:0] data);
        io_cycle(EXT_INDEX_PORT, 1'b1, idx);
        io_cycle(EXT_DATA_PORT, 1'b0, 8'h00);
        @(negedge mclk);
        data = rdata;
    endtask : ext_read

    task automatic set_freq(input logic [1:0] sel, input logic [16:0] khz);
        ext_write(IDX_CLK_SELECT, {6'h00, sel});
        ext_write(IDX_CLK_FREQ_LO, khz[7:0]);
        ext_write(IDX_CLK_FREQ_MID, khz[15:8]);
        ext_write(IDX_CLK_FREQ_HI, {7'h00, khz[16]});
    endtask : set_freq

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // whole run needs about 1040 cycles; a hang is cut well past that
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            $display("[FAIL] %0t run did not complete", $time);
            finish_test();
        end
    end

    initial begin
        rst = 1'b1;
        pattern = 8'h00;
        io_addr = 16'h0000;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        ext_write(IDX_CLK_CHOICE, 8'h02);
        ext_read(IDX_CLK_CHOICE, rd_val);
        check(rd_val[1:0], 2'h2, "choice readback");
        check(choice, 2'h2, "choice output");
        exp_f = '{MCLK_DEFAULT_KHZ, VCLK0_DEFAULT_KHZ, VCLK1_DEFAULT_KHZ};
        for (int i = 0; i < 6; i++) begin
            set_freq(fsel[i][1:0], fval[i]);
            if (fval[i] >= FREQ_MIN_KHZ && fval[i] <= FREQ_MAX_KHZ) begin
                exp_f[fsel[i]] = fval[i];
            end
            repeat (2) @(negedge mclk);
            check(mclk_khz, exp_f[0], "mclk setting");
            check(vclk0_khz, exp_f[1], "vclk0 setting");
            check(vclk1_khz, exp_f[2], "vclk1 setting");
        end
        ext_read(8'h7F, rd_val);
        check(rd_val, 8'h00, "unmapped index");
        ext_read(IDX_CLK_CHOICE, rd_val);
        check(rd_val, 8'h02, "choice held");
        io_cycle(16'h03D5, 1'b0, 8'h00);
        @(negedge mclk);
        check(rdata, 8'h00, "foreign port");
        $display("test clock registers done");
        for (int p = 0; p < 5; p++) begin
            @(negedge mclk);
            pattern = pats[p];
            rst = 1'b1;
            repeat (150) @(negedge mclk);
            rst = 1'b0;
            @(negedge mclk);
            check(latch, pats[p], "latch");
            check(bus_type, pats[p][1:0], "bus type");
            check(on_mb, pats[p][2], "board");
            check(chip_dis, pats[p][3], "disable");
            check(ext_clk, pats[p][4], "clock source");
            check(ref_osc, !pats[p][4] & pats[p][5], "reference");
            check(pix_xtal, pats[p][4], "pixel clock pin");
            check(mem_pin, pats[p][4], "memory clock pin");
            check(mclk_khz, 17'h0EA60, "mclk default");
            check(vclk0_khz, 17'h06257, "vclk0 default");
            check(vclk1_khz, 17'h06EA2, "vclk1 default");
            check(choice, 2'h0, "choice default");
            ext_write(IDX_STRAP_LATCH, ~pats[p]);
            repeat (20) @(negedge mclk);
            ext_read(IDX_STRAP_LATCH, rd_val);
            check(rd_val, pats[p], "latch readback");
            check(latch, pats[p], "latch held");
            $display("test strap pattern %0h done", pats[p]);
        end
        finish_test();
    end
endmodule : strap_config_block_test
